// ===== core/fpcr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpcr_map.svh"

module fpcr_top #(
	parameter int unsigned WS_CYCLES = `FPCR_T_WS_NS / `FPCR_CLK_NS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic serial_clock,
	input wire logic serial_lane_in,
	output logic serial_lane_out,
	output logic serial_lane_out_en,
	input wire logic mem_op_req,
	input wire logic mem_op_erase,
	input wire fpcr_pkg::fpcr_sector_t mem_op_sector,
	input wire logic mem_op_busy,
	input wire logic mem_fail_prog,
	input wire logic mem_fail_erase,
	input wire logic erase_susp,
	input wire logic prog_susp,
	output logic mem_op_grant,
	output logic mem_op_denied,
	output logic addr_four_byte,
	output logic [3:0] dummy_quad,
	output logic [3:0] dummy_single
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic sck_s1_q, sck_s2_q, sck_s3_q;
	logic din_s1_q, din_s2_q;
	logic sck_rise, sck_fall, cs_rise;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
		end else begin
			cs_s1_q <= chip_select_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			sck_s1_q <= serial_clock;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			din_s1_q <= serial_lane_in;
			din_s2_q <= din_s1_q;
		end
	end

	assign sck_rise = sck_s2_q & ~sck_s3_q;
	assign sck_fall = ~sck_s2_q & sck_s3_q;
	assign cs_rise = cs_s2_q & ~cs_s3_q;

	// ----------------------------------------
	// serial frame engine
	// ----------------------------------------
	logic [5:0] cnt_q, cnt_d, idx;
	logic [7:0] sh_q, sh_d, op_q, op_d;
	logic [15:0] data_q, data_d;
	logic out_q, out_d, oe_q, oe_d;
	logic is_read, rd_bit;
	logic [7:0] sr_view, fsr_view;
	logic [15:0] cfg_q;

	always_comb begin
		idx = cnt_q - `FPCR_BITS_OPC;
		is_read = (op_q == `FPCR_OP_RDSR) || (op_q == `FPCR_OP_RDFS)
			|| (op_q == `FPCR_OP_RDCF);
		unique case (op_q)
			`FPCR_OP_RDFS: rd_bit = fsr_view[3'h7 - idx[2:0]];
			`FPCR_OP_RDCF: rd_bit = (idx < 6'h10) ? cfg_q[4'hF - idx[3:0]] : 1'b0;
			default: rd_bit = sr_view[3'h7 - idx[2:0]];
		endcase
	end

	always_comb begin
		cnt_d = cnt_q;
		sh_d = sh_q;
		op_d = op_q;
		data_d = data_q;
		out_d = out_q;
		oe_d = oe_q;
		if (cs_s2_q) begin
			cnt_d = 6'h00;
			out_d = 1'b0;
			oe_d = 1'b0;
		end else begin
			if (sck_rise) begin
				sh_d = {sh_q[6:0], din_s2_q};
				if (cnt_q == `FPCR_BITS_OPC - 6'h01) begin
					op_d = {sh_q[6:0], din_s2_q};
				end else if (cnt_q >= `FPCR_BITS_OPC && cnt_q < `FPCR_BITS_WRCF) begin
					data_d = {data_q[14:0], din_s2_q};
				end
				cnt_d = (cnt_q == `FPCR_BITS_MAX) ? `FPCR_BITS_WRAP : cnt_q + 6'h01;
			end
			if (sck_fall && cnt_q >= `FPCR_BITS_OPC && is_read) begin
				oe_d = 1'b1;
				out_d = rd_bit;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 6'h00;
			sh_q <= 8'h00;
			op_q <= 8'h00;
			data_q <= 16'h0000;
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			op_q <= op_d;
			data_q <= data_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// ----------------------------------------
	// registers, timed writes and flags
	// ----------------------------------------
	fpcr_pkg::fpcr_wstate_t st_q, st_d;
	logic [19:0] tmr_q, tmr_d;
	logic wel_q, wel_d;
	logic [4:0] prot_q, prot_d;
	logic [15:0] cfg_d, pend_q, pend_d;
	logic e_ers_q, e_ers_d, e_prg_q, e_prg_d, e_prt_q, e_prt_d;
	logic grant_q, grant_d, deny_q, deny_d;
	logic addr_q, addr_d;
	logic [3:0] dq_q, dq_d, ds_q, ds_d, dcode;
	logic write_active_flag, busy_hit, wrsr_ok, wrcf_ok;

	fpcr_sector_guard u_guard (
		.protect_from_bottom(prot_q[3]),
		.level({prot_q[4], prot_q[2:0]}),
		.sector(mem_op_sector),
		.is_protected(busy_hit)
	);

	assign write_active_flag = (st_q != fpcr_pkg::FPCR_W_IDLE) || mem_op_busy;
	assign sr_view = {1'b0, prot_q, wel_q, write_active_flag};
	assign fsr_view = {~write_active_flag, erase_susp, e_ers_q, e_prg_q, 1'b0, prog_susp, e_prt_q,
		~cfg_q[0]};
	assign wrsr_ok = cs_rise && op_q == `FPCR_OP_WRSR && cnt_q == `FPCR_BITS_WRSR
		&& wel_q && !write_active_flag;
	assign wrcf_ok = cs_rise && op_q == `FPCR_OP_WRCF && cnt_q == `FPCR_BITS_WRCF
		&& wel_q && !write_active_flag;
	assign dcode = cfg_q[`FPCR_CFG_DUMMY_HI:`FPCR_CFG_DUMMY_LO];

	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		wel_d = wel_q;
		prot_d = prot_q;
		cfg_d = cfg_q;
		pend_d = pend_q;
		e_ers_d = e_ers_q;
		e_prg_d = e_prg_q;
		e_prt_d = e_prt_q;
		grant_d = 1'b0;
		deny_d = 1'b0;
		if (st_q != fpcr_pkg::FPCR_W_IDLE) begin
			if (tmr_q == 20'(WS_CYCLES - 1)) begin
				if (st_q == fpcr_pkg::FPCR_W_STATUS) begin
					prot_d = pend_q[6:2];
				end else begin
					cfg_d = pend_q;
				end
				st_d = fpcr_pkg::FPCR_W_IDLE;
				tmr_d = 20'h00000;
				wel_d = 1'b0;
			end else begin
				tmr_d = tmr_q + 20'h00001;
			end
		end
		if (cs_rise && cnt_q == `FPCR_BITS_OPC && op_q == `FPCR_OP_WREN) begin
			wel_d = 1'b1;
			e_ers_d = 1'b0;
			e_prg_d = 1'b0;
			e_prt_d = 1'b0;
		end
		if (cs_rise && cnt_q == `FPCR_BITS_OPC && op_q == `FPCR_OP_WRDI) begin
			wel_d = 1'b0;
		end
		if (wrsr_ok) begin
			st_d = fpcr_pkg::FPCR_W_STATUS;
			pend_d = {8'h00, data_q[7:0]};
		end
		if (wrcf_ok) begin
			st_d = fpcr_pkg::FPCR_W_CONFIG;
			pend_d = data_q;
		end
		if (mem_op_req) begin
			if (busy_hit) begin
				deny_d = 1'b1;
				e_prt_d = 1'b1;
				if (mem_op_erase) begin
					e_ers_d = 1'b1;
				end else begin
					e_prg_d = 1'b1;
				end
			end else begin
				grant_d = 1'b1;
			end
		end
		if (mem_fail_erase) begin
			e_ers_d = 1'b1;
		end
		if (mem_fail_prog) begin
			e_prg_d = 1'b1;
		end
		addr_d = ~cfg_q[`FPCR_CFG_ADDR_BIT];
		if (dcode == `FPCR_DUMMY_DEF_A || dcode == `FPCR_DUMMY_DEF_B) begin
			dq_d = `FPCR_DUMMY_DEF_QUAD;
			ds_d = `FPCR_DUMMY_DEF_SINGLE;
		end else begin
			dq_d = dcode;
			ds_d = dcode;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= fpcr_pkg::FPCR_W_IDLE;
			tmr_q <= 20'h00000;
			wel_q <= 1'b0;
			prot_q <= 5'h00;
			cfg_q <= `FPCR_CFG_RST;
			pend_q <= 16'h0000;
			e_ers_q <= 1'b0;
			e_prg_q <= 1'b0;
			e_prt_q <= 1'b0;
			grant_q <= 1'b0;
			deny_q <= 1'b0;
			addr_q <= 1'b0;
			dq_q <= `FPCR_DUMMY_DEF_QUAD;
			ds_q <= `FPCR_DUMMY_DEF_SINGLE;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			wel_q <= wel_d;
			prot_q <= prot_d;
			cfg_q <= cfg_d;
			pend_q <= pend_d;
			e_ers_q <= e_ers_d;
			e_prg_q <= e_prg_d;
			e_prt_q <= e_prt_d;
			grant_q <= grant_d;
			deny_q <= deny_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			ds_q <= ds_d;
		end
	end

	assign serial_lane_out = out_q;
	assign serial_lane_out_en = oe_q;
	assign mem_op_grant = grant_q;
	assign mem_op_denied = deny_q;
	assign addr_four_byte = addr_q;
	assign dummy_quad = dq_q;
	assign dummy_single = ds_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	flag_busy_inv_a: assert property (fsr_view[7] == ~sr_view[0])
		else $error("flag ready bit not inverse of write active");
	wrsr_start_a: assert property (wrsr_ok |=> st_q == fpcr_pkg::FPCR_W_STATUS ##1 write_active_flag)
		else $error("status write did not start");
	wrsr_nolatch_a: assert property (
		cs_rise && op_q == `FPCR_OP_WRSR && !wel_q && st_q == fpcr_pkg::FPCR_W_IDLE
		|=> st_q == fpcr_pkg::FPCR_W_IDLE)
		else $error("status write ran without write latch");
	wrsr_partial_a: assert property (
		cs_rise && op_q == `FPCR_OP_WRSR && cnt_q != `FPCR_BITS_WRSR
		&& st_q == fpcr_pkg::FPCR_W_IDLE |=> st_q == fpcr_pkg::FPCR_W_IDLE)
		else $error("partial frame accepted");
	wrsr_apply_a: assert property (
		st_q == fpcr_pkg::FPCR_W_STATUS && st_d == fpcr_pkg::FPCR_W_IDLE
		|=> prot_q == $past(pend_q[6:2]) && !wel_q)
		else $error("status write applied wrong bits");
	wip_hold_a: assert property ($rose(st_q == fpcr_pkg::FPCR_W_STATUS) |-> write_active_flag [*2])
		else $error("write active dropped early");
	prot_deny_a: assert property (mem_op_req && busy_hit |=> deny_q && !grant_q && e_prt_q)
		else $error("protected sector not refused");
	top_last_a: assert property (
		mem_op_req && !prot_q[3] && {prot_q[4], prot_q[2:0]} == 4'h1
		&& mem_op_sector == 11'h7FF |=> deny_q)
		else $error("top sector not protected");
	bot_first_a: assert property (
		mem_op_req && prot_q[3] && {prot_q[4], prot_q[2:0]} == 4'h1
		&& mem_op_sector == 11'h001 |=> grant_q)
		else $error("sector 1 wrongly protected");
	addr_width_a: assert property (addr_q == $past(~cfg_q[0]) && fsr_view[0] == ~cfg_q[0])
		else $error("address width mismatch");
	cfg_tail_a: assert property (
		!cs_s2_q && sck_fall && op_q == `FPCR_OP_RDCF && cnt_q >= 6'h18 |=> !out_q)
		else $error("config read tail not zero");
	deselect_a: assert property (cs_rise |=> cnt_q == 6'h00 ##1 !oe_q)
		else $error("deselect did not reset decoder");

	cover property (st_q == fpcr_pkg::FPCR_W_STATUS ##1 st_q == fpcr_pkg::FPCR_W_IDLE);
	cover property (st_q == fpcr_pkg::FPCR_W_CONFIG ##1 st_q == fpcr_pkg::FPCR_W_IDLE);
	cover property (deny_q);
	cover property (oe_q && op_q == `FPCR_OP_RDFS && write_active_flag);

endmodule // fpcr_top
`default_nettype wire

// ===== core/fpcr_map.svh
`ifndef FPCR_MAP_SVH
`define FPCR_MAP_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define FPCR_OP_WRSR 8'h01
`define FPCR_OP_WRDI 8'h04
`define FPCR_OP_RDSR 8'h05
`define FPCR_OP_WREN 8'h06
`define FPCR_OP_RDFS 8'h70
`define FPCR_OP_WRCF 8'hB1
`define FPCR_OP_RDCF 8'hB5

// ----------------------------------------
// frame lengths in serial clock bits
// ----------------------------------------
`define FPCR_BITS_OPC 6'h08
`define FPCR_BITS_WRSR 6'h10
`define FPCR_BITS_WRCF 6'h18
`define FPCR_BITS_WRAP 6'h38
`define FPCR_BITS_MAX 6'h3F

// ----------------------------------------
// sector array and protection levels
// ----------------------------------------
`define FPCR_SECTORS 12'h800
`define FPCR_LVL_ALL 4'hC

// ----------------------------------------
// configuration register fields and reset
// ----------------------------------------
`define FPCR_CFG_RST 16'hFFFF
`define FPCR_CFG_DUMMY_HI 15
`define FPCR_CFG_DUMMY_LO 12
`define FPCR_CFG_ADDR_BIT 0
`define FPCR_DUMMY_DEF_QUAD 4'hA
`define FPCR_DUMMY_DEF_SINGLE 4'h8
`define FPCR_DUMMY_DEF_A 4'h0
`define FPCR_DUMMY_DEF_B 4'hF

// ----------------------------------------
// timing
// ----------------------------------------
`define FPCR_CLK_NS 8
`define FPCR_T_WS_NS 5000000

`endif

// ===== core/fpcr_pkg.sv
package fpcr_pkg;

	typedef enum logic [1:0] {
		FPCR_W_IDLE,
		FPCR_W_STATUS,
		FPCR_W_CONFIG
	} fpcr_wstate_t;

	typedef logic [10:0] fpcr_sector_t;

endpackage

// ===== core/fpcr_sector_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpcr_map.svh"

module fpcr_sector_guard (
	input wire logic protect_from_bottom,
	input wire logic [3:0] level,
	input wire fpcr_pkg::fpcr_sector_t sector,
	output logic is_protected
);

	logic [11:0] span;
	logic [11:0] sec_w;

	always_comb begin
		span = 12'h001 << (level - 4'h1);
		sec_w = {1'b0, sector};
		if (level == 4'h0) begin
			is_protected = 1'b0;
		end else if (level >= `FPCR_LVL_ALL) begin
			is_protected = 1'b1;
		end else if (protect_from_bottom) begin
			is_protected = sec_w < span;
		end else begin
			is_protected = sec_w >= (`FPCR_SECTORS - span);
		end
	end

endmodule // fpcr_sector_guard
`default_nettype wire

// ===== tb/fpcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpcr_host_model (
	output logic chip_select_n,
	output logic serial_clock,
	output logic serial_lane_in,
	input wire logic serial_lane_out
);
	initial begin
		chip_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_lane_in = 1'b0;
	end
	// ----
	// one framed command
	// ----
	// msb first, bits
	task automatic frame(input logic [7:0] op, input logic [15:0] w, input int wb, input int rb,
		output logic [31:0] rd);
		logic [23:0] sh;
		sh = {op, w << (16 - wb)};
		rd = 32'h0000_0000;
		chip_select_n = 1'b0;
		repeat (8 + wb) begin
			serial_lane_in = sh[23];
			sh = sh << 1;
			#32 serial_clock = 1'b1;
			#32 serial_clock = 1'b0;
		end
		// sampled late in the high phase, after the device has updated
		repeat (rb) begin
			serial_lane_in = ~serial_lane_in;
			#32 serial_clock = 1'b1;
			#31 rd = {rd[30:0], serial_lane_out};
			#1 serial_clock = 1'b0;
		end
		#32 chip_select_n = 1'b1;
		serial_lane_in = ~serial_lane_in;
		#64;
	endtask
endmodule // fpcr_host_model
`default_nettype wire

// ===== tb/fpcr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fpcr_top_tb;
	localparam int WS = 400;
	logic core_clk, rst_n, chip_select_n, serial_clock, serial_lane_in;
	logic serial_lane_out, serial_lane_out_en, mem_op_req, mem_op_erase, mem_op_busy;
	logic mem_fail_prog, mem_fail_erase, erase_susp, prog_susp;
	logic mem_op_grant, mem_op_denied, addr_four_byte, p;
	logic [3:0] dummy_quad, dummy_single, c;
	fpcr_pkg::fpcr_sector_t mem_op_sector;
	logic [31:0] r;
	int bad_count, tests_run, cyc, n, s;
	int sl[6];
	int cl[4];
	fpcr_top #(.WS_CYCLES(WS)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.chip_select_n(chip_select_n), .serial_clock(serial_clock),
		.serial_lane_in(serial_lane_in), .serial_lane_out(serial_lane_out),
		.serial_lane_out_en(serial_lane_out_en), .mem_op_req(mem_op_req),
		.mem_op_erase(mem_op_erase), .mem_op_sector(mem_op_sector), .mem_op_busy(mem_op_busy),
		.mem_fail_prog(mem_fail_prog), .mem_fail_erase(mem_fail_erase),
		.erase_susp(erase_susp), .prog_susp(prog_susp), .mem_op_grant(mem_op_grant),
		.mem_op_denied(mem_op_denied), .addr_four_byte(addr_four_byte),
		.dummy_quad(dummy_quad), .dummy_single(dummy_single));
	fpcr_host_model host_u (.chip_select_n(chip_select_n), .serial_clock(serial_clock),
		.serial_lane_in(serial_lane_in), .serial_lane_out(serial_lane_out));
	// ----
	// helpers
	// ----
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [15:0] w, input int wb, input int rb);
		host_u.frame(op, w, wb, rb, r);
	endtask
	task automatic poll();
		n = 0;
		do begin
			cmd(8'h70, 16'h0000, 0, 8);
			n++;
		end while (r[7] !== 1'b1 && n < 20);
	endtask
	task automatic memop(input logic er, input int sec);
		@(posedge core_clk);
		#1 mem_op_req = 1'b1;
		mem_op_erase = er;
		mem_op_sector = sec[10:0];
		@(posedge core_clk);
		#1 mem_op_req = 1'b0;
	endtask
	function automatic logic prot(input int b, input int l, input int sec);
		if (l == 0) return 1'b0;
		if (l >= 12) return 1'b1;
		return (b == 1) ? (sec < (1 << (l - 1))) : (sec >= 2048 - (1 << (l - 1)));
	endfunction
	// ----
	// tests
	// ----
	initial begin
		rst_n = 1'b0;
		{mem_op_req, mem_op_erase, mem_op_busy, mem_fail_prog} = 4'h0;
		{mem_fail_erase, erase_susp, prog_susp} = 3'h0;
		mem_op_sector = 11'h000;
		{bad_count, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (12) @(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge core_clk);
		chk({23'h0, addr_four_byte, dummy_quad, dummy_single}, 32'h0000_00A8);
		cmd(8'hB5, 16'h0000, 0, 24);
		chk(r, 32'h00FF_FF00);
		chk({31'h0, serial_lane_out_en}, 32'h0000_0000);
		cmd(8'h70, 16'h0000, 0, 16);
		chk(r, 32'h0000_8080);
		#1 {erase_susp, prog_susp, mem_op_busy} = 3'h7;
		cmd(8'h70, 16'h0000, 0, 8);
		chk(r, 32'h0000_0044);
		#1 {erase_susp, prog_susp, mem_op_busy} = 3'h0;
		memop(1'b0, 0);
		#1 {mem_fail_prog, mem_fail_erase} = 2'h3;
		@(posedge core_clk);
		#1 {mem_fail_prog, mem_fail_erase} = 2'h0;
		cmd(8'h70, 16'h0000, 0, 8);
		chk(r, 32'h0000_00B0);
		$display("test flags done");
		cmd(8'h04, 16'h0000, 0, 0);
		cmd(8'h01, 16'h007C, 8, 0);
		cmd(8'h05, 16'h0000, 0, 8);
		chk(r, 32'h0000_0000);
		cmd(8'h06, 16'h0000, 0, 0);
		cmd(8'h01, 16'h007C, 7, 0);
		cmd(8'h05, 16'h0000, 0, 8);
		chk(r, 32'h0000_0002);
		cmd(8'h01, 16'h00FF, 8, 0);
		cmd(8'h70, 16'h0000, 0, 8);
		chk(r, 32'h0000_0000);
		cmd(8'h05, 16'h0000, 0, 8);
		chk(r, 32'h0000_0003);
		poll();
		chk({31'h0, n < 6}, 32'h0000_0001);
		cmd(8'h05, 16'h0000, 0, 8);
		chk(r, 32'h0000_007C);
		$display("test status write done");
		for (int b = 0; b < 2; b++) begin
			for (int l = 0; l < 16; l++) begin
				cmd(8'h06, 16'h0000, 0, 0);
				cmd(8'h01, {9'h000, l[3], b[0], l[2:0], 2'b00}, 8, 0);
				poll();
				s = (l > 0 && l < 12) ? (1 << (l - 1)) : 1024;
				sl = '{0, 2047, s - 1, s, 2048 - s, 2047 - s};
				for (int i = 0; i < 6; i++) begin
					p = prot(b, l, sl[i]);
					memop(i[0], sl[i]);
					chk({30'h0, mem_op_grant, mem_op_denied}, {30'h0, !p, p});
				end
			end
		end
		cmd(8'h06, 16'h0000, 0, 0);
		memop(1'b1, 5);
		cmd(8'h70, 16'h0000, 0, 8);
		chk(r, 32'h0000_00A2);
		$display("test protection done");
		cmd(8'h06, 16'h0000, 0, 0);
		cmd(8'hB1, 16'h5FEE, 16, 0);
		poll();
		chk({23'h0, addr_four_byte, dummy_quad, dummy_single}, 32'h0000_0155);
		cmd(8'h70, 16'h0000, 0, 8);
		chk(r, 32'h0000_0081);
		cmd(8'hB5, 16'h0000, 0, 16);
		chk(r, 32'h0000_5FEE);
		cl = '{0, 1, 14, 15};
		for (int i = 0; i < 4; i++) begin
			c = cl[i][3:0];
			cmd(8'h06, 16'h0000, 0, 0);
			cmd(8'hB1, {c, 12'hFEF}, 16, 0);
			poll();
			s = (c == 4'h0 || c == 4'hF) ? 32'h0000_00A8 : {24'h0, c, c};
			chk({23'h0, addr_four_byte, dummy_quad, dummy_single}, s);
		end
		$display("test configuration done");
		close_out();
	end
endmodule // fpcr_top_tb
`default_nettype wire
